// [rtl/sees_regs.sv]
// Chosen here: register access over APB.
module sees_regs
   import sees_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire sees_lane_in_t [LANES-1:0] lane_in,
   output logic [3:0] scan_mode,
   output logic recovery_freeze,
   output logic [7:0] signal_loss_level_mv,
   output logic [8:0] equalizer_votes,
   output logic irq
);
   sees_bus_state_t state_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic clr_bit_r;
   logic [3:0] signal_loss_threshold_r;
   logic signal_loss_enable_r;
   logic [3:0] vote_r;
   logic freeze_r;
   logic [3:0] mode_r;
   logic run_start_r;
   logic count_clear_r;
   logic [IRQ_W-1:0] stat_r;
   logic [IRQ_W-1:0] mask_r;
   logic irq_r;
   logic [7:0] los_mv_r;
   logic [8:0] votes_r;
   logic [LANES-1:0] done_vec;
   logic [LANES-1:0] done_d_r;
   sees_lane_out_t [LANES-1:0] lane_out;
   logic [IDX_W-1:0] idx;
   logic take;
   logic wr;
   logic [31:0] rd_nxt;
   logic map_hit;
   logic [IRQ_W-1:0] events;

   function automatic logic [8:0] vote_decode(input logic [3:0] code);
      case (code)
         4'h2: vote_decode = 9'h001;
         4'h3: vote_decode = 9'h003;
         4'h4: vote_decode = 9'h007;
         4'h5: vote_decode = 9'h00f;
         4'h6: vote_decode = 9'h01f;
         4'h7: vote_decode = 9'h03f;
         4'h8: vote_decode = 9'h07f;
         4'h9: vote_decode = 9'h0ff;
         default: vote_decode = VOTES_DEFAULT;
      endcase
   endfunction

   function automatic logic lane_slot(input logic [IDX_W-1:0] a, input logic [IDX_W-1:0] base);
      lane_slot = a >= base && a < base + 10'(LANES);
   endfunction

   assign idx = paddr[11:2];
   assign take = psel && !penable && state_r == SEES_IDLE;
   assign wr = psel && penable && pready_r && pwrite && !pslverr_r;

   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : gen_lane
         sees_lane u_lane (
            .pclk(pclk),
            .presetn(presetn),
            .scan_mode(mode_r),
            .run_start(run_start_r),
            .count_clear(count_clear_r),
            .lane_in(lane_in[g]),
            .lane_out(lane_out[g])
         );
         assign done_vec[g] = lane_out[g].done;
      end
   endgenerate

   // bus handshake: one wait-free access per transfer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= SEES_IDLE;
         pready_r <= 1'b0;
      end else begin
         case (state_r)
            SEES_IDLE: begin
               if (take) begin
                  state_r <= SEES_ACCESS;
                  pready_r <= 1'b1;
               end
            end
            SEES_ACCESS: begin
               state_r <= SEES_IDLE;
               pready_r <= 1'b0;
            end
            default: begin
               state_r <= SEES_IDLE;
               pready_r <= 1'b0;
            end
         endcase
      end
   end

   // read decode
   always_comb begin
      rd_nxt = 32'h0000_0000;
      map_hit = 1'b1;
      if (idx == IDX_CNT_CLR) begin
         rd_nxt[0] = clr_bit_r;
      end else if (idx == IDX_DONE) begin
         rd_nxt[LANES-1:0] = done_vec;
      end else if (lane_slot(idx, IDX_VOLT_BASE)) begin
         rd_nxt[5:0] = lane_out[4'(idx - IDX_VOLT_BASE)].voltage;
      end else if (lane_slot(idx, IDX_COUNT_BASE)) begin
         rd_nxt[15:0] = lane_out[4'(idx - IDX_COUNT_BASE)].count;
      end else if (idx == IDX_SIGNAL_LOSS_THRESHOLD) begin
         rd_nxt[3:0] = signal_loss_threshold_r;
      end else if (idx == IDX_VOTE) begin
         rd_nxt[3:0] = vote_r;
      end else if (idx == IDX_FREEZE) begin
         rd_nxt[0] = freeze_r;
      end else if (idx == IDX_SCAN_CTRL) begin
         rd_nxt[3:0] = mode_r;
      end else if (idx == IDX_SIGNAL_LOSS_ENABLE) begin
         rd_nxt[0] = signal_loss_enable_r;
      end else if (idx == IDX_IRQ_STAT) begin
         rd_nxt[IRQ_W-1:0] = stat_r;
      end else if (idx == IDX_IRQ_MASK) begin
         rd_nxt[IRQ_W-1:0] = mask_r;
      end else begin
         map_hit = 1'b0;
      end
   end

   // read data and error captured at setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (take) begin
         prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
         pslverr_r <= !map_hit;
      end else if (state_r == SEES_ACCESS) begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
   end

   // clear pulse on the one-to-zero write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clr_bit_r <= RST_CNT_CLR;
         count_clear_r <= 1'b0;
      end else begin
         count_clear_r <= 1'b0;
         if (wr && idx == IDX_CNT_CLR && pstrb[0]) begin
            clr_bit_r <= pwdata[0];
            count_clear_r <= clr_bit_r && !pwdata[0];
         end
      end
   end

   // shared settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         signal_loss_threshold_r <= RST_SIGNAL_LOSS_THRESHOLD;
         signal_loss_enable_r <= RST_SIGNAL_LOSS_ENABLE;
         vote_r <= RST_VOTE;
         freeze_r <= RST_FREEZE;
      end else if (wr && pstrb[0]) begin
         if (idx == IDX_SIGNAL_LOSS_THRESHOLD) begin
            signal_loss_threshold_r <= pwdata[3:0];
         end else if (idx == IDX_SIGNAL_LOSS_ENABLE) begin
            signal_loss_enable_r <= pwdata[0];
         end else if (idx == IDX_VOTE) begin
            vote_r <= pwdata[3:0];
         end else if (idx == IDX_FREEZE) begin
            freeze_r <= pwdata[0];
         end
      end
   end

   // scan mode and run start strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= RST_SCAN_MODE;
         run_start_r <= 1'b0;
      end else begin
         run_start_r <= 1'b0;
         if (wr && idx == IDX_SCAN_CTRL && pstrb[0]) begin
            mode_r <= pwdata[3:0];
            run_start_r <= pwdata[SCAN_START_BIT];
         end
      end
   end

   // level in mV, reserved codes give zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         los_mv_r <= 8'h00;
      end else if (signal_loss_enable_r && signal_loss_threshold_r >= SIGNAL_LOSS_THRESHOLD_MIN) begin
         los_mv_r <= 8'(signal_loss_threshold_r) * 8'(LOS_STEP_MV);
      end else begin
         los_mv_r <= 8'h00;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         votes_r <= VOTES_DEFAULT;
      end else begin
         votes_r <= vote_decode(vote_r);
      end
   end

   assign events[IRQ_LANE_DONE] = |(done_vec & ~done_d_r);
   assign events[IRQ_CNT_CLR] = count_clear_r;

   // sticky status, set wins over write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_d_r <= '0;
         stat_r <= '0;
         mask_r <= '0;
         irq_r <= 1'b0;
      end else begin
         done_d_r <= done_vec;
         if (wr && idx == IDX_IRQ_STAT && pstrb[0]) begin
            stat_r <= (stat_r & ~pwdata[IRQ_W-1:0]) | events;
         end else begin
            stat_r <= stat_r | events;
         end
         if (wr && idx == IDX_IRQ_MASK && pstrb[0]) begin
            mask_r <= pwdata[IRQ_W-1:0];
         end
         irq_r <= |(stat_r & mask_r);
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign scan_mode = mode_r;
   assign recovery_freeze = freeze_r;
   assign signal_loss_level_mv = los_mv_r;
   assign equalizer_votes = votes_r;
   assign irq = irq_r;

   chk_clear_sequence: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && idx == IDX_CNT_CLR && pstrb[0] && clr_bit_r && !pwdata[0])
      |=> count_clear_r ##1 (!count_clear_r && lane_out[0].count == 16'h0000))
      else $error("counter clear sequence failed");
   // no pulse without a prior one
   chk_clear_needs_one: assert property (@(posedge pclk) disable iff (!presetn)
      count_clear_r |-> $past(clr_bit_r) && !clr_bit_r)
      else $error("clear pulse without one-to-zero");
   chk_done_readback: assert property (@(posedge pclk) disable iff (!presetn)
      (take && !pwrite && idx == IDX_DONE)
      |=> prdata_r == {16'h0000, $past(done_vec)})
      else $error("done vector read wrong");
   chk_volt_width: assert property (@(posedge pclk) disable iff (!presetn)
      (take && !pwrite && lane_slot(idx, IDX_VOLT_BASE)) |=> prdata_r[31:6] == 26'h0)
      else $error("voltage result has stray bits");
   chk_count_read: assert property (@(posedge pclk) disable iff (!presetn)
      (take && !pwrite && idx == IDX_COUNT_BASE)
      |=> prdata_r == {16'h0000, $past(lane_out[0].count)})
      else $error("lane 0 count read wrong");
   chk_los_level: assert property (@(posedge pclk) disable iff (!presetn)
      (signal_loss_enable_r && signal_loss_threshold_r == 4'h4 && $stable(signal_loss_threshold_r)) |=> los_mv_r == 8'h3c)
      else $error("loss level not 15 mV per code");
   chk_los_gated: assert property (@(posedge pclk) disable iff (!presetn)
      !signal_loss_enable_r |=> los_mv_r == 8'h00)
      else $error("loss level while disabled");
   chk_vote_default: assert property (@(posedge pclk) disable iff (!presetn)
      vote_r == 4'h0 |=> votes_r == 9'h1ff)
      else $error("vote default not 511");
   chk_freeze_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && idx == IDX_FREEZE && pstrb[0]) |=> recovery_freeze == $past(pwdata[0]))
      else $error("freeze not applied");
   chk_bus_answer: assert property (@(posedge pclk) disable iff (!presetn)
      take |=> pready_r ##1 !pready_r)
      else $error("access not answered in one cycle");

   cov_clear: cover property (@(posedge pclk) disable iff (!presetn) count_clear_r);
   cov_all_done: cover property (@(posedge pclk) disable iff (!presetn) &done_vec);
   cov_irq: cover property (@(posedge pclk) disable iff (!presetn) irq_r);
   cov_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pready_r && pslverr_r);
endmodule

// [rtl/sees_pkg.sv]
package sees_pkg;
   localparam int LANES = 16;
   localparam int IDX_W = 10;
   localparam logic [IDX_W-1:0] IDX_CNT_CLR = 10'h1f5;
   localparam logic [IDX_W-1:0] IDX_DONE = 10'h1f6;
   localparam logic [IDX_W-1:0] IDX_VOLT_BASE = 10'h200;
   localparam logic [IDX_W-1:0] IDX_COUNT_BASE = 10'h210;
   localparam logic [IDX_W-1:0] IDX_SIGNAL_LOSS_THRESHOLD = 10'h234;
   localparam logic [IDX_W-1:0] IDX_VOTE = 10'h235;
   localparam logic [IDX_W-1:0] IDX_FREEZE = 10'h238;
   localparam logic [IDX_W-1:0] IDX_SCAN_CTRL = 10'h240;
   localparam logic [IDX_W-1:0] IDX_SIGNAL_LOSS_ENABLE = 10'h241;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h242;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h243;
   localparam logic RST_CNT_CLR = 1'b0;
   localparam logic [3:0] RST_SIGNAL_LOSS_THRESHOLD = 4'h8;
   localparam logic [3:0] RST_VOTE = 4'h0;
   localparam logic RST_FREEZE = 1'b0;
   localparam logic [3:0] RST_SCAN_MODE = 4'h0;
   localparam logic RST_SIGNAL_LOSS_ENABLE = 1'b0;
   localparam logic [3:0] SIGNAL_LOSS_THRESHOLD_MIN = 4'h2;
   localparam logic [3:0] LOS_STEP_MV = 4'hf;
   localparam int SCAN_START_BIT = 4;
   localparam logic [3:0] MODE_COMPARE = 4'h1;
   localparam logic [3:0] MODE_ZEROS = 4'h2;
   localparam logic [3:0] MODE_ONES = 4'h3;
   localparam logic [3:0] MODE_COUNT_ONES = 4'h4;
   localparam logic [8:0] VOTES_DEFAULT = 9'h1ff;
   localparam int IRQ_W = 2;
   localparam int IRQ_LANE_DONE = 0;
   localparam int IRQ_CNT_CLR = 1;
   typedef enum logic [1:0] {
      SEES_IDLE = 2'b01,
      SEES_ACCESS = 2'b10
   } sees_bus_state_t;
   typedef struct packed {
      logic normal_bit;
      logic scan_bit;
      logic sample_valid;
      logic finish;
      logic [5:0] voltage;
   } sees_lane_in_t;
   typedef struct packed {
      logic done;
      logic [5:0] voltage;
      logic [15:0] count;
   } sees_lane_out_t;
endpackage

// [rtl/sees_lane.sv]
module sees_lane
   import sees_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] scan_mode,
   input wire logic run_start,
   input wire logic count_clear,
   input wire sees_lane_in_t lane_in,
   output sees_lane_out_t lane_out
);
   logic done_r;
   logic [5:0] volt_r;
   logic [15:0] count_r;
   logic hit;

   // compare counts over zeros and ones
   always_comb begin
      hit = 1'b0;
      if (lane_in.sample_valid && !done_r) begin
         case (scan_mode)
            MODE_COMPARE: hit = lane_in.normal_bit != lane_in.scan_bit;
            MODE_ZEROS: hit = !lane_in.normal_bit && lane_in.scan_bit;
            MODE_ONES: hit = lane_in.normal_bit && !lane_in.scan_bit;
            MODE_COUNT_ONES: hit = lane_in.scan_bit;
            default: hit = 1'b0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= 16'h0000;
      end else if (count_clear) begin
         count_r <= 16'h0000;
      end else if (hit && count_r != 16'hffff) begin
         count_r <= count_r + 16'h0001;
      end
   end

   // done set on finish, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_r <= 1'b0;
      end else if (lane_in.finish) begin
         done_r <= 1'b1;
      end else if (run_start) begin
         done_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         volt_r <= 6'h00;
      end else if (lane_in.finish) begin
         volt_r <= lane_in.voltage;
      end
   end

   assign lane_out.done = done_r;
   assign lane_out.voltage = volt_r;
   assign lane_out.count = count_r;

   chk_compare_counts: assert property (@(posedge pclk) disable iff (!presetn)
      (scan_mode == MODE_COMPARE && lane_in.sample_valid && !done_r && !count_clear
       && lane_in.normal_bit != lane_in.scan_bit && count_r != 16'hffff)
      |=> count_r == $past(count_r) + 16'h0001)
      else $error("compare mismatch not counted");
   chk_run_clears_done: assert property (@(posedge pclk) disable iff (!presetn)
      run_start && !lane_in.finish |=> !done_r)
      else $error("done not cleared by run start");
   chk_finish_sets_done: assert property (@(posedge pclk) disable iff (!presetn)
      lane_in.finish |=> done_r && volt_r == $past(lane_in.voltage))
      else $error("finish did not set done and result");
endmodule

// [tb/sees_regs_test.sv]
module sees_regs_test
   import sees_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [3:0] wstrb = 4'hf;
   sees_lane_in_t [LANES-1:0] lane_in = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] scan_mode;
   logic recovery_freeze;
   logic [7:0] signal_loss_level_mv;
   logic [8:0] equalizer_votes;
   logic irq;
   logic [31:0] rdat;
   logic rerr;
   int num_errors = 0;
   int n_compared = 0;

   always #10 pclk = ~pclk;

   sees_regs DUT (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .lane_in(lane_in),
      .scan_mode(scan_mode),
      .recovery_freeze(recovery_freeze),
      .signal_loss_level_mv(signal_loss_level_mv),
      .equalizer_votes(equalizer_votes),
      .irq(irq)
   );

   task automatic print_verdict;
      if (num_errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer: setup, then access until pready is sampled high
   task automatic xfer(input logic [9:0] idx, input logic w, input logic [31:0] d);
      int t;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      pstrb <= wstrb;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      rdat = prdata;
      rerr = pslverr;
      if (t >= 50) begin
         num_errors++;
         $display("FAIL %0t no pready", $time);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      xfer(idx, 1'b1, d);
   endtask

   task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
      xfer(idx, 1'b0, 32'h0);
      chk(rdat, exp);
      chk({31'h0, rerr}, 32'h0);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   function automatic logic [8:0] votes_of(input int c);
      if (c >= 2 && c <= 9) begin
         return 9'((1 << (c - 1)) - 1);
      end
      return 9'h1ff;
   endfunction

   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      $display("FAIL %0t watchdog expired", $time);
      print_verdict();
   end

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      settle(1);
      chk(32'(equalizer_votes), 32'h1ff);
      chk(32'(signal_loss_level_mv), 32'h0);
      chk(32'(recovery_freeze), 32'h0);
      rchk(IDX_CNT_CLR, 32'h0);
      rchk(IDX_SIGNAL_LOSS_THRESHOLD, 32'h8);
      rchk(IDX_VOTE, 32'h0);
      rchk(IDX_FREEZE, 32'h0);
      wr(IDX_DONE, 32'hffff);
      rchk(IDX_DONE, 32'h0);
      xfer(10'h3ff, 1'b0, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      chk(rdat, 32'h0);
      for (int en = 0; en < 2; en++) begin
         wr(IDX_SIGNAL_LOSS_ENABLE, 32'(en));
         for (int c = 0; c < 16; c++) begin
            wr(IDX_SIGNAL_LOSS_THRESHOLD, 32'(c));
            settle(1);
            chk(32'(signal_loss_level_mv), (en == 1 && c >= 2) ? 32'(15 * c) : 32'h0);
            rchk(IDX_SIGNAL_LOSS_THRESHOLD, 32'(c));
         end
      end
      for (int c = 0; c < 16; c++) begin
         wr(IDX_VOTE, 32'(c));
         settle(1);
         chk(32'(equalizer_votes), 32'(votes_of(c)));
         rchk(IDX_VOTE, 32'(c));
      end
      wr(IDX_VOTE, 32'h0);
      wstrb = 4'he;
      wr(IDX_FREEZE, 32'h1);
      wstrb = 4'hf;
      rchk(IDX_FREEZE, 32'h0);
      wr(IDX_FREEZE, 32'h1);
      settle(1);
      chk(32'(recovery_freeze), 32'h1);
      rchk(IDX_FREEZE, 32'h1);
      wr(IDX_FREEZE, 32'h0);
      settle(1);
      chk(32'(recovery_freeze), 32'h0);
      for (int m = 1; m <= 4; m++) begin
         wr(IDX_SCAN_CTRL, 32'(m) | 32'h10);
         rchk(IDX_DONE, 32'h0);
         rchk(IDX_SCAN_CTRL, 32'(m));
         chk(32'(scan_mode), 32'(m));
         wr(IDX_CNT_CLR, 32'h1);
         wr(IDX_CNT_CLR, 32'h0);
         settle(2);
         rchk(IDX_COUNT_BASE + 10'h5, 32'h0);
         for (int rep = 0; rep < 16; rep++) begin
            for (int k = 0; k < 4; k++) begin
               @(posedge pclk);
               for (int n = 0; n < LANES; n++) begin
                  lane_in[n].sample_valid <= (rep <= n);
                  lane_in[n].normal_bit <= k[0];
                  lane_in[n].scan_bit <= k[1];
               end
            end
         end
         @(posedge pclk);
         for (int n = 0; n < LANES; n++) begin
            lane_in[n].sample_valid <= 1'b0;
            lane_in[n].finish <= 1'b1;
            lane_in[n].voltage <= 6'(n * 3 + m);
         end
         @(posedge pclk);
         for (int n = 0; n < LANES; n++) begin
            lane_in[n].finish <= 1'b0;
         end
         rchk(IDX_DONE, 32'hffff);
         for (int n = 0; n < LANES; n++) begin
            rchk(IDX_VOLT_BASE + 10'(n), 32'(n * 3 + m));
            rchk(IDX_COUNT_BASE + 10'(n), 32'(((m == 1 || m == 4) ? 2 : 1) * (n + 1)));
         end
      end
      wr(IDX_CNT_CLR, 32'h1);
      settle(2);
      rchk(IDX_COUNT_BASE + 10'h3, 32'h8);
      wr(IDX_CNT_CLR, 32'h0);
      settle(2);
      rchk(IDX_COUNT_BASE + 10'h3, 32'h0);
      rchk(IDX_IRQ_STAT, 32'h3);
      chk(32'(irq), 32'h0);
      wr(IDX_IRQ_MASK, 32'h1);
      settle(2);
      chk(32'(irq), 32'h1);
      wr(IDX_IRQ_STAT, 32'h1);
      settle(2);
      chk(32'(irq), 32'h0);
      rchk(IDX_IRQ_STAT, 32'h2);
      wr(IDX_IRQ_MASK, 32'h3);
      settle(2);
      chk(32'(irq), 32'h1);
      wr(IDX_IRQ_STAT, 32'h2);
      settle(2);
      chk(32'(irq), 32'h0);
      rchk(IDX_IRQ_STAT, 32'h0);
      print_verdict();
   end
endmodule
